/* File: pkg/cwl_pkg.sv */
// Constants for the configuration word loader.
// Assumes a 24-bit program flash word and a 24-bit table access bus.
package cwl_pkg;
    localparam int unsigned CWL_ADDR_W = 24;
    localparam int unsigned CWL_WORD_W = 24;
    // Configuration space and mapped bit locations
    localparam logic [23:0] CWL_CFG_SPACE_LO = 24'h80_0000;
    localparam logic [23:0] CWL_CFG_SPACE_HI = 24'hFF_FFFF;
    localparam logic [23:0] CWL_CFG_BASE     = 24'hF8_0000;
    localparam int unsigned CWL_CFG_LOCS     = 5;
    // Where the five volatile locations sit in configuration space
    localparam logic [23:0] CWL_LOC_STEP     = 24'h00_0002;
    // Flash word addresses per memory size: word 1 and word 2
    localparam logic [23:0] CWL_W1_SZ0 = 24'h00_ABFE;
    localparam logic [23:0] CWL_W2_SZ0 = 24'h00_ABFC;
    localparam logic [23:0] CWL_W1_SZ1 = 24'h00_FFFE;
    localparam logic [23:0] CWL_W2_SZ1 = 24'h00_FFFC;
    localparam logic [23:0] CWL_W1_SZ2 = 24'h01_57FE;
    localparam logic [23:0] CWL_W2_SZ2 = 24'h01_57FC;
    // Word 1 field positions
    localparam int unsigned W1_RSV   = 15;
    localparam int unsigned W1_SCAN  = 14;
    localparam int unsigned W1_CP    = 13;
    localparam int unsigned W1_WP    = 12;
    localparam int unsigned W1_DBG   = 11;
    localparam int unsigned W1_EMU   = 10;
    localparam int unsigned W1_U9    = 9;
    localparam int unsigned W1_PAIR  = 8;
    localparam int unsigned W1_WDTEN = 7;
    localparam int unsigned W1_WIN   = 6;
    localparam int unsigned W1_U5    = 5;
    localparam int unsigned W1_PRE   = 4;
    localparam int unsigned W1_POST  = 0;
    // Implemented (program-once) bits of each word
    localparam logic [23:0] CWL_W1_IMPL = 24'h00_7DDF;
    localparam logic [23:0] CWL_W2_IMPL = 24'h00_87E3;
    // Unimplemented bits read as one in word 1 (bits 15, 9, 5); 23..16 read 0
    localparam logic [23:0] CWL_W1_ONES = 24'h00_8220;
    localparam logic [23:0] CWL_W2_ONES = 24'h00_781C;
    localparam logic [23:0] CWL_W2_UP   = 24'hFF_0000;
    localparam logic [23:0] CWL_ALL1    = 24'hFF_FFFF;
    localparam logic [2:0]  CWL_PRE_128 = 3'd7;
    localparam logic [2:0]  CWL_PRE_32  = 3'd5;
    typedef enum logic [3:0] {
        CWL_IDLE = 4'b0001,
        CWL_RD1  = 4'b0010,
        CWL_RD2  = 4'b0100,
        CWL_DONE = 4'b1000
    } cwl_state_e;
endpackage

/* File: src/cwl_field_decode.sv */
// Decodes configuration word 1 into control levels.
// Assumes the word comes from registers in the loader.
`timescale 1ns/100ps
`default_nettype none
module cwl_field_decode
(
    input  wire logic [cwl_pkg::CWL_WORD_W-1:0] cfg_word1,
    output logic                                 scan_port_enable,
    output logic                                 code_read_protect_n,
    output logic                                 flash_write_protect_n,
    output logic                                 debug_reset_mode_n,
    output logic                                 emulation_reset_mode_n,
    output logic                                 debugger_pin_pair_sel,
    output logic                                 watchdog_enable_cfg,
    output logic                                 window_mode_off,
    output logic [2:0]                           watchdog_prescale_log2,
    output logic [3:0]                           watchdog_postscale_sel
);
    import cwl_pkg::*;
    assign scan_port_enable       = cfg_word1[W1_SCAN];
    assign code_read_protect_n    = cfg_word1[W1_CP];
    assign flash_write_protect_n  = cfg_word1[W1_WP];
    assign debug_reset_mode_n     = cfg_word1[W1_DBG];
    assign emulation_reset_mode_n = cfg_word1[W1_EMU];
    assign debugger_pin_pair_sel  = cfg_word1[W1_PAIR];
    assign watchdog_enable_cfg    = cfg_word1[W1_WDTEN];
    // Window mode only counts while the watchdog is on
    assign window_mode_off = cfg_word1[W1_WIN] | ~cfg_word1[W1_WDTEN];
    assign watchdog_prescale_log2 = cfg_word1[W1_PRE] ? CWL_PRE_128
                                                      : CWL_PRE_32;
    assign watchdog_postscale_sel = cfg_word1[W1_POST +: 4];
endmodule
`default_nettype wire

/* File: src/cwl_config_loader.sv */
// Configuration word loader: volatile program-once cells filled from flash.
// Assumes a flash read port answering with valid within 16 cycles of a request, and a
// table access port for configuration space from the CPU.
`timescale 1ns/100ps
`default_nettype none
module cwl_config_loader
#(
    parameter logic [1:0] MEM_SIZE_SEL = 2'd2
)
(
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    input  wire logic                            por,
    output logic                                 flash_rd_req,
    output logic [cwl_pkg::CWL_ADDR_W-1:0]       flash_rd_addr,
    input  wire logic [cwl_pkg::CWL_WORD_W-1:0]  flash_rd_data,
    input  wire logic                            flash_rd_valid,
    input  wire logic                            tbl_rd,
    input  wire logic                            tbl_wr,
    input  wire logic [cwl_pkg::CWL_ADDR_W-1:0]  tbl_addr,
    input  wire logic [cwl_pkg::CWL_WORD_W-1:0]  tbl_wdata,
    output logic [cwl_pkg::CWL_WORD_W-1:0]       tbl_rdata,
    output logic                                 tbl_hit,
    output logic                                 load_done,
    output logic                                 scan_port_enable,
    output logic                                 code_read_protect_n,
    output logic                                 flash_write_protect_n,
    output logic                                 debug_reset_mode_n,
    output logic                                 emulation_reset_mode_n,
    output logic                                 debugger_pin_pair_sel,
    output logic                                 watchdog_enable_cfg,
    output logic                                 window_mode_off,
    output logic [2:0]                           watchdog_prescale_log2,
    output logic [3:0]                           watchdog_postscale_sel
);
    import cwl_pkg::*;

    cwl_state_e  state_r;
    logic [23:0] cell_r [CWL_CFG_LOCS];
    logic [23:0] locked_r [CWL_CFG_LOCS];
    logic        loaded_r;
    logic [23:0] word1_view;
    logic [23:0] word2_view;
    logic [23:0] rdata_nxt;
    logic [2:0]  loc_idx;
    logic [23:0] loc_off;
    logic        loc_ok;
    logic        in_space;

    function automatic logic [23:0] w1_addr(input logic [1:0] sz);
        case (sz)
            2'd0:    w1_addr = CWL_W1_SZ0;
            2'd1:    w1_addr = CWL_W1_SZ1;
            default: w1_addr = CWL_W1_SZ2;
        endcase
    endfunction

    function automatic logic [23:0] w2_addr(input logic [1:0] sz);
        case (sz)
            2'd0:    w2_addr = CWL_W2_SZ0;
            2'd1:    w2_addr = CWL_W2_SZ1;
            default: w2_addr = CWL_W2_SZ2;
        endcase
    endfunction

    // Program-once merge: only unlocked implemented bits may go low
    function automatic logic [23:0] po_merge(input logic [23:0] cur,
                                             input logic [23:0] lck,
                                             input logic [23:0] val,
                                             input logic [23:0] impl);
        logic [23:0] open_bits;
        open_bits = impl & ~lck;
        po_merge  = (cur & ~open_bits) | (val & open_bits);
    endfunction

    function automatic logic [23:0] po_lock(input logic [23:0] lck,
                                            input logic [23:0] val,
                                            input logic [23:0] impl);
        po_lock = lck | (impl & ~val);
    endfunction

    // Word 1 and 2 live in locations 0 and 1; 2..4 hold spare cells
    assign in_space = (tbl_addr >= CWL_CFG_SPACE_LO)
                    && (tbl_addr <= CWL_CFG_SPACE_HI);
    // Range test on the full offset: a 3-bit index alone would alias
    assign loc_off  = tbl_addr - CWL_CFG_BASE;
    assign loc_idx  = loc_off[3:1];
    assign loc_ok   = in_space && (tbl_addr >= CWL_CFG_BASE)
                    && (tbl_addr[0] == 1'b0)
                    && (loc_off[23:1] < 23'(CWL_CFG_LOCS));

    // Readback forces fixed bits; cells themselves read as stored
    assign word1_view = (cell_r[0] & CWL_W1_IMPL) | CWL_W1_ONES;
    assign word2_view = (cell_r[1] & CWL_W2_IMPL) | CWL_W2_ONES | CWL_W2_UP;

    always_ff @(posedge sys_clk)
    begin
        if (rst && por)
            state_r <= CWL_RD1;
        else if (rst)
            state_r <= CWL_DONE;
        else
        begin
            case (state_r)
                CWL_RD1:
                    if (flash_rd_valid)
                        state_r <= CWL_RD2;
                CWL_RD2:
                    if (flash_rd_valid)
                        state_r <= CWL_DONE;
                CWL_DONE:
                    state_r <= CWL_DONE;
                default:
                    state_r <= CWL_IDLE;
            endcase
        end
    end

    // Cells and lock masks; power-on returns cells to one and clears locks
    always_ff @(posedge sys_clk)
    begin
        if (rst && por)
        begin
            for (int i = 0; i < CWL_CFG_LOCS; i++)
            begin
                cell_r[i]   <= CWL_ALL1;
                locked_r[i] <= '0;
            end
        end
        else if (!rst)
        begin
            if ((state_r == CWL_RD1) && flash_rd_valid)
            begin
                cell_r[0]   <= po_merge(cell_r[0], locked_r[0],
                                        flash_rd_data, CWL_W1_IMPL);
                locked_r[0] <= po_lock(locked_r[0], flash_rd_data,
                                       CWL_W1_IMPL);
            end
            else if ((state_r == CWL_RD2) && flash_rd_valid)
            begin
                cell_r[1]   <= po_merge(cell_r[1], locked_r[1],
                                        flash_rd_data, CWL_W2_IMPL);
                locked_r[1] <= po_lock(locked_r[1], flash_rd_data,
                                       CWL_W2_IMPL);
            end
            else if (tbl_wr && loc_ok && loaded_r && (state_r == CWL_DONE))
            begin
                // Already programmed bits are held: no error, no change
                cell_r[loc_idx]   <= po_merge(cell_r[loc_idx],
                                              locked_r[loc_idx], tbl_wdata,
                                              (loc_idx == 3'd1) ? CWL_W2_IMPL
                                                                : CWL_W1_IMPL);
                locked_r[loc_idx] <= po_lock(locked_r[loc_idx], tbl_wdata,
                                             (loc_idx == 3'd1) ? CWL_W2_IMPL
                                                               : CWL_W1_IMPL);
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst && por)
            loaded_r <= 1'b0;
        else if ((state_r == CWL_RD2) && flash_rd_valid)
            loaded_r <= 1'b1;
    end

    always_comb
    begin
        rdata_nxt = '0;
        if (loc_idx == 3'd0)
            rdata_nxt = word1_view;
        else if (loc_idx == 3'd1)
            rdata_nxt = word2_view;
        else
            rdata_nxt = cell_r[loc_idx];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tbl_rdata <= '0;
            tbl_hit   <= 1'b0;
        end
        else
        begin
            tbl_hit <= (tbl_rd | tbl_wr) & loc_ok;
            if (tbl_rd && loc_ok)
                tbl_rdata <= rdata_nxt;
            else if (tbl_rd)
                tbl_rdata <= '0;
        end
    end

    assign flash_rd_req  = (state_r == CWL_RD1) || (state_r == CWL_RD2);
    assign flash_rd_addr = (state_r == CWL_RD2) ? w2_addr(MEM_SIZE_SEL)
                                                : w1_addr(MEM_SIZE_SEL);
    assign load_done     = (state_r == CWL_DONE);

    cwl_field_decode u_decode
    (
        .cfg_word1              (word1_view),
        .scan_port_enable       (scan_port_enable),
        .code_read_protect_n    (code_read_protect_n),
        .flash_write_protect_n  (flash_write_protect_n),
        .debug_reset_mode_n     (debug_reset_mode_n),
        .emulation_reset_mode_n (emulation_reset_mode_n),
        .debugger_pin_pair_sel  (debugger_pin_pair_sel),
        .watchdog_enable_cfg    (watchdog_enable_cfg),
        .window_mode_off        (window_mode_off),
        .watchdog_prescale_log2 (watchdog_prescale_log2),
        .watchdog_postscale_sel (watchdog_postscale_sel)
    );

    property p_por_ones;
        @(posedge sys_clk) (rst && por) |=> (cell_r[0] == CWL_ALL1);
    endproperty
    a_por_ones: assert property (p_por_ones) else $error("cells not one");

    property p_warm_keep;
        @(posedge sys_clk) (rst && !por && $past(!rst))
            |=> (cell_r[0] == $past(cell_r[0]));
    endproperty
    a_warm_keep: assert property (p_warm_keep) else $error("warm lost");

    // Word 2 sits one flash word below word 1 in every memory size
    localparam logic [23:0] PAIR_GAP = CWL_W1_SZ2 - CWL_W2_SZ2;

    // Slow flash may take up to 16 cycles per word
    sequence s_por_release;
        (rst && por) ##1 !rst;
    endsequence

    sequence s_word1;
        (state_r == CWL_RD1) ##[1:16] (state_r == CWL_RD2);
    endsequence

    sequence s_word2;
        (state_r == CWL_RD2) ##[1:16] (state_r == CWL_DONE);
    endsequence

    property p_load_seq;
        @(posedge sys_clk) s_por_release |-> s_word1 ##0 s_word2;
    endproperty
    a_load_seq: assert property (p_load_seq) else $error("load order");

    property p_load_addr;
        @(posedge sys_clk) disable iff (rst)
            ((state_r == CWL_RD2) && ($past(state_r) == CWL_RD1))
                |-> (flash_rd_addr == $past(flash_rd_addr) - PAIR_GAP);
    endproperty
    a_load_addr: assert property (p_load_addr) else $error("bad word addr");

    property p_once;
        @(posedge sys_clk) disable iff (rst)
            (locked_r[0][W1_SCAN] && state_r == CWL_DONE) |=> !cell_r[0][W1_SCAN];
    endproperty
    a_once: assert property (p_once) else $error("locked bit rose");

    property p_upper_zero;
        @(posedge sys_clk) disable iff (rst)
            (tbl_rd && loc_ok && loc_idx == 3'd0) |=> (tbl_rdata[23:16] == 8'h00);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper nonzero");

    property p_unimpl_one;
        @(posedge sys_clk) word1_view[W1_U9] && word1_view[W1_U5];
    endproperty
    a_unimpl_one: assert property (p_unimpl_one) else $error("bit 9/5 low");

    property p_space;
        @(posedge sys_clk) disable iff (rst)
            (tbl_rd && !in_space) |=> !tbl_hit;
    endproperty
    a_space: assert property (p_space) else $error("hit outside");

    property p_wp;
        @(posedge sys_clk) disable iff (rst)
            flash_write_protect_n == cell_r[0][W1_WP];
    endproperty
    a_wp: assert property (p_wp) else $error("write protect wrong");

    property p_win;
        @(posedge sys_clk) !cell_r[0][W1_WDTEN] |-> window_mode_off;
    endproperty
    a_win: assert property (p_win) else $error("window w/o wdt");

    property p_no_reload;
        @(posedge sys_clk) (rst && !por) |=> !flash_rd_req;
    endproperty
    a_no_reload: assert property (p_no_reload) else $error("warm reload");

    // Locks only fall at power-on; a warm reset must not reopen them
    property p_lock_keep;
        @(posedge sys_clk) !(rst && por)
            |=> ((locked_r[0] | $past(locked_r[0])) == locked_r[0]);
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lock lost");

    property p_por_unlock;
        @(posedge sys_clk) (rst && por) |=> (locked_r[0] == '0);
    endproperty
    a_por_unlock: assert property (p_por_unlock) else $error("lock kept");

    property p_upper_nop;
        @(posedge sys_clk) disable iff (rst)
            (cell_r[0][23:16] == CWL_ALL1[23:16]);
    endproperty
    a_upper_nop: assert property (p_upper_nop) else $error("upper changed");

    property p_miss_zero;
        @(posedge sys_clk) disable iff (rst)
            (tbl_rd && !loc_ok) |=> (tbl_rdata == '0);
    endproperty
    a_miss_zero: assert property (p_miss_zero) else $error("miss data");

    property p_prog_low;
        @(posedge sys_clk) disable iff (rst)
            (tbl_wr && loc_ok && (loc_idx == 3'd0) && load_done && loaded_r
             && !tbl_wdata[W1_SCAN]) |=> !scan_port_enable;
    endproperty
    a_prog_low: assert property (p_prog_low) else $error("not programmed");

    property p_hit_next;
        @(posedge sys_clk) disable iff (rst)
            (tbl_wr && loc_ok) |=> tbl_hit;
    endproperty
    a_hit_next: assert property (p_hit_next) else $error("write no hit");
endmodule
`default_nettype wire

/* File: dv/cwl_flash_model.sv */
// Behavioural program flash holding the two configuration words.
// Assumes the loader holds request and address until valid is seen.
`timescale 1ns/100ps
`default_nettype none
module cwl_flash_model
(
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [23:0] cfg_w1,
    input  wire logic [23:0] cfg_w2,
    input  wire logic        rd_req,
    input  wire logic [23:0] rd_addr,
    output logic [23:0]      rd_data,
    output logic             rd_valid,
    output logic [23:0]      seen_prev,
    output logic [23:0]      seen_last
);
    import cwl_pkg::*;
    logic [3:0] wait_cnt;
    initial
    begin
        wait_cnt = 4'h0;
        rd_valid = 1'b0;
        rd_data = 24'h5A_A5A5;
        seen_prev = 24'h00_0000;
        seen_last = 24'h00_0000;
    end
    // Slow answers catch a loader that samples data without valid
    always @(posedge clk)
    begin
        rd_valid <= 1'b0;
        if (rd_req && !rd_valid)
        begin
            if (wait_cnt >= (slow ? 4'h6 : 4'h0))
            begin
                rd_valid <= 1'b1;
                wait_cnt <= 4'h0;
                seen_prev <= seen_last;
                seen_last <= rd_addr;
                if (rd_addr == CWL_W1_SZ2)
                    rd_data <= cfg_w1;
                else if (rd_addr == CWL_W2_SZ2)
                    rd_data <= cfg_w2;
                else
                    rd_data <= ~rd_data;
            end
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
        else
        begin
            wait_cnt <= 4'h0;
            rd_data <= ~rd_data; // Stale outside the answer cycle
        end
    end
endmodule
`default_nettype wire

/* File: dv/config_word_loader_test.sv */
// Self-checking bench for the configuration word loader.
// Assumes the flash model in dv/ and a 250 MHz system clock.
`timescale 1ns/100ps
`default_nettype none
module config_word_loader_test;
    import cwl_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        por = 1'b1;
    logic        slow = 1'b0;
    logic        tbl_rd = 1'b0;
    logic        tbl_wr = 1'b0;
    logic [23:0] tbl_addr = 24'h00_0000;
    logic [23:0] tbl_wdata = 24'h00_0000;
    logic [23:0] w1 = 24'hFF_FFFF;
    logic [23:0] w2 = 24'hFF_7A1E;
    logic        rd_req, rd_valid, tbl_hit, load_done;
    logic [23:0] rd_addr, rd_data, tbl_rdata, seen_prev, seen_last;
    logic        scan, cp_n, wp_n, dbg_n, emu_n, pair, wdt, win_off;
    logic [2:0]  pre;
    logic [3:0]  post;
    logic [14:0] dec;
    int          n_fail = 0;
    int          samples_checked = 0;
    // Inputs: word 1 (upper byte ones, windowed only with watchdog on)
    logic [23:0] row_w [4] = '{24'hFF_FFFF, 24'hFF_8080,
                              24'hFF_D5DA, 24'hFF_AAA5};
    // Outputs: eight mode levels, prescale log2, postscale code
    logic [14:0] row_d [4] = '{{8'hFF, 3'd7, 4'hF}, {8'h02, 3'd5, 4'h0},
                              {8'hAF, 3'd7, 4'hA}, {8'h52, 3'd5, 4'h5}};
    logic [23:0] bad_a [4] = '{24'h7F_FFFE, 24'hF8_0001, 24'hF8_000A,
                              24'hF8_0010};
    assign dec = {scan, cp_n, wp_n, dbg_n, emu_n, pair, wdt, win_off, pre, post};
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    cwl_config_loader #(.MEM_SIZE_SEL(2'd2)) dut (
        .sys_clk(sys_clk), .rst(rst), .por(por),
        .flash_rd_req(rd_req), .flash_rd_addr(rd_addr),
        .flash_rd_data(rd_data), .flash_rd_valid(rd_valid),
        .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr),
        .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_hit(tbl_hit),
        .load_done(load_done), .scan_port_enable(scan),
        .code_read_protect_n(cp_n), .flash_write_protect_n(wp_n),
        .debug_reset_mode_n(dbg_n), .emulation_reset_mode_n(emu_n),
        .debugger_pin_pair_sel(pair), .watchdog_enable_cfg(wdt),
        .window_mode_off(win_off), .watchdog_prescale_log2(pre),
        .watchdog_postscale_sel(post));
    cwl_flash_model flash (
        .clk(sys_clk), .slow(slow), .cfg_w1(w1), .cfg_w2(w2),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .seen_prev(seen_prev), .seen_last(seen_last));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_load();
        int n;
        n = 0;
        while (load_done !== 1'b1 && n < 100)
        begin
            tick();
            n++;
        end
        check(load_done, 1'b1);
    endtask
    task automatic power_on();
        tick();
        rst = 1'b1;
        por = 1'b1;
        tick();
        rst = 1'b0;
        por = 1'b0;
        wait_load();
    endtask
    task automatic access(input logic wr, input logic [23:0] a,
                          input logic [23:0] d);
        tick();
        tbl_rd = !wr;
        tbl_wr = wr;
        tbl_addr = a;
        tbl_wdata = d;
        tick();
        tbl_rd = 1'b0;
        tbl_wr = 1'b0;
    endtask
    function automatic logic [23:0] view1(input logic [23:0] w);
        return (w & CWL_W1_IMPL) | CWL_W1_ONES;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #40000;
        n_fail++;
        report_and_stop();
    end
    initial
    begin
        repeat (16) tick();
        rst = 1'b0;
        por = 1'b0;
        wait_load();
        for (int i = 0; i < 4; i++)
        begin
            w1 = row_w[i];
            slow = i[0];
            power_on();
            check({9'h000, dec}, {9'h000, row_d[i]});
            check(dec[14:7], row_d[i][14:7]);
            check(dec[9:7], row_d[i][9:7]);
            access(1'b0, CWL_CFG_BASE, 24'h00_0000);
            check(tbl_rdata, view1(row_w[i]));
            check(tbl_hit, 1'b1);
        end
        $display("decode rows done");
        for (int c = 0; c < 16; c++)
        begin
            w1 = {CWL_ALL1[23:5], c[0], c[3:0]};
            power_on();
            check(post, c[3:0]);
            check(pre, c[0] ? 3'd7 : 3'd5);
        end
        $display("watchdog scale codes done");
        check(seen_prev, CWL_W1_SZ2);
        check(seen_last, CWL_W2_SZ2);
        access(1'b0, CWL_CFG_BASE + CWL_LOC_STEP, 24'h00_0000);
        check(tbl_rdata, (w2 & CWL_W2_IMPL) | CWL_W2_ONES | CWL_W2_UP);
        access(1'b0, 24'hF8_0008, 24'h00_0000);
        check(tbl_hit, 1'b1);
        foreach (bad_a[k])
        begin
            access(1'b0, bad_a[k], 24'h00_0000);
            check(tbl_hit, 1'b0);
            check(tbl_rdata, 24'h00_0000);
        end
        $display("address map done");
        access(1'b1, CWL_CFG_BASE, 24'hFF_BFFF);
        check(scan, 1'b0);
        access(1'b1, CWL_CFG_BASE, 24'hFF_FFFF);
        access(1'b0, CWL_CFG_BASE, 24'h00_0000);
        check(tbl_rdata, view1(24'hFF_BFFF));
        check(scan, 1'b0);
        tick();
        rst = 1'b1;
        tick();
        rst = 1'b0;
        tick();
        check({rd_req, load_done, scan}, 3'b010);
        access(1'b1, CWL_CFG_BASE, 24'hFF_FFFF);
        check(scan, 1'b0);
        $display("program once done");
        tick();
        rst = 1'b1;
        por = 1'b1;
        tick();
        check(dec[14:7], 8'hFF);
        rst = 1'b0;
        por = 1'b0;
        wait_load();
        check(scan, 1'b1);
        $display("power cycle done");
        report_and_stop();
    end
endmodule
`default_nettype wire
